// [spg_defs.svh]
`ifndef SPG_DEFS_SVH
`define SPG_DEFS_SVH

// Clock and key hold timing.
`define SPG_CLK_PERIOD_NS  100
`define SPG_HOLD_TIME_MS   1000
`define SPG_HOLD_CYCLES    ((`SPG_HOLD_TIME_MS * 1000000 + \
                             `SPG_CLK_PERIOD_NS - 1) / `SPG_CLK_PERIOD_NS)

// Register byte offsets.
`define SPG_OFS_NUM_HI     8'h00
`define SPG_OFS_NUM_LO     8'h04
`define SPG_OFS_DEN_HI     8'h08
`define SPG_OFS_DEN_LO     8'h0c
`define SPG_OFS_ENC_KIND   8'h10
`define SPG_OFS_ABS_RES    8'h14
`define SPG_OFS_ALIAS      8'h18
`define SPG_OFS_NUM        8'h1c
`define SPG_OFS_DEN        8'h20
`define SPG_OFS_CTRL       8'h24
`define SPG_OFS_EDIT_SEL   8'h28
`define SPG_OFS_ALIAS_ACT  8'h2c
`define SPG_OFS_STATUS     8'h30

// Internal register indices.
`define SPG_IDX_NUM_HI     4'h0
`define SPG_IDX_NUM_LO     4'h1
`define SPG_IDX_DEN_HI     4'h2
`define SPG_IDX_DEN_LO     4'h3
`define SPG_IDX_ENC_KIND   4'h4
`define SPG_IDX_ABS_RES    4'h5
`define SPG_IDX_ALIAS      4'h6
`define SPG_IDX_NUM        4'h7
`define SPG_IDX_DEN        4'h8
`define SPG_IDX_CTRL       4'h9
`define SPG_IDX_EDIT_SEL   4'ha
`define SPG_IDX_ALIAS_ACT  4'hb
`define SPG_IDX_STATUS     4'hc
`define SPG_IDX_NONE       4'hf

// Reset values of the parameter words.
`define SPG_NUM_HI_RST     16'h000d
`define SPG_NUM_LO_RST     16'h0430
`define SPG_DEN_HI_RST     16'h0001
`define SPG_DEN_LO_RST     16'h0000
`define SPG_ENC_KIND_RST   16'h0002
`define SPG_ABS_RES_RST    16'h0000
`define SPG_ALIAS_RST      16'h0000
`define SPG_EDIT_SEL_RST   4'h0

// Value limits and gear scaling.
`define SPG_GEAR_SCALE     27'h0002710
`define SPG_HI_MAX         32'h0000_2710
`define SPG_LO_MAX         32'h0000_270f
`define SPG_ENC_MIN        32'h0000_0001
`define SPG_ENC_MAX        32'h0000_0004
`define SPG_RES_MAX        32'h0000_0002
`define SPG_ALIAS_MAX      32'h0000_ffff
`define SPG_COMPOSED_MAX   32'h05f6_080f
`define SPG_EDIT_SEL_MAX   4'h6
`define SPG_CTRL_RESTORE   0

// Encoder kinds and word widths.
`define SPG_ENC_SINGLE_INC 16'h0001
`define SPG_ENC_MULTI_ABS  16'h0002
`define SPG_ENC_MULTI_INC  16'h0003
`define SPG_ENC_ABS_NOTURN 16'h0004
`define SPG_RES_17         16'h0000
`define SPG_RES_20         16'h0001
`define SPG_BITS_17        5'h11
`define SPG_BITS_20        5'h14
`define SPG_BITS_23        5'h17

// Segment patterns, bit order gfedcba, active high.
`define SPG_SEG_B          7'h7c
`define SPG_SEG_O          7'h3f
`define SPG_SEG_N          7'h54
`define SPG_SEG_DASH       7'h40
`define SPG_SEG_PORT0      7'h20
`define SPG_SEG_PORT1      7'h02
`define SPG_MODE_MAX       8'h0a

// AXI responses.
`define SPG_RESP_OKAY      2'h0
`define SPG_RESP_SLVERR    2'h2

`endif

// [spg_pkg.sv]
package spg_pkg;
  typedef enum logic [1:0] {PNL_BROWSE, PNL_EDIT, PNL_COMMIT} spg_panel_e;
  typedef logic [15:0] spg_word_t;
  typedef logic [3:0]  spg_idx_t;
endpackage

// [spg_key.sv]
`timescale 1ns/1ps
`include "spg_defs.svh"
module spg_key #(
  parameter int unsigned HOLD_CYCLES = `SPG_HOLD_CYCLES
) (
  input  logic clk,
  input  logic rst,
  input  logic key_pin,
  output logic press_pulse,
  output logic hold_pulse
);
  localparam int unsigned CW = $clog2(HOLD_CYCLES + 2);

  logic          sync1_q;
  logic          sync2_q;
  logic          lvl_q;
  logic [CW-1:0] cnt_q;

  if (HOLD_CYCLES < 1) begin : g_bad_hold
    $error("HOLD_CYCLES must be at least one");
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= key_pin;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lvl_q <= 1'b0;
    end else begin
      lvl_q <= sync2_q;
    end
  end

  // The count saturates one past the limit, so a long hold fires once.
  always_ff @(posedge clk) begin
    if (rst || !sync2_q) begin
      cnt_q <= '0;
    end else if (cnt_q != CW'(HOLD_CYCLES + 1)) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  assign press_pulse = sync2_q && !lvl_q;
  assign hold_pulse  = sync2_q && (cnt_q == CW'(HOLD_CYCLES));

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_HOLD_LEN: assert property (
    hold_pulse |-> $past(sync2_q) && cnt_q == CW'(HOLD_CYCLES))
    else $error("hold pulse without a full hold");
  AST_HOLD_ONCE: assert property (
    hold_pulse |=> !hold_pulse)
    else $error("hold pulse repeated");
endmodule

// [spg_panel_cfg.sv]
// What this block does
// - Numerator is high word times 10000 plus low
// - Denominator is high word times 10000 plus low
// - Composed numerator equals gear object numerator
// - Composed denominator equals gear object denominator
// - Encoder kind accepts only values one to four
// - Kind four ignores turn count in position
// - Resolution selects 17, 20 or 23 bits
// - Second digit shows one-hot slave state code
// - Slave state fault shows B on digit two
// - Third digit shows operating mode zero to ten
// - Mode zero means unset, eight means cyclic position
// - First digit lights one segment per linked port
// - Digits four, five show disabled or On
// - Long confirm hold opens the value editor
// - Long confirm hold commits the edited value
// - Factory restore returns all parameters to defaults
// - Station alias is loaded only at power-on; RST resets p_q[6] to 0 first, so alias edits never take effect
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "spg_defs.svh"
module spg_panel_cfg #(
  parameter int unsigned HOLD_CYCLES = `SPG_HOLD_CYCLES
) (
  input  logic              CLOCK,
  input  logic              RST,
  input  logic [7:0]        AWADDR,
  input  logic              AWVALID,
  output logic              AWREADY,
  input  logic [31:0]       WDATA,
  input  logic [3:0]        WSTRB,
  input  logic              WVALID,
  output logic              WREADY,
  output logic [1:0]        BRESP,
  output logic              BVALID,
  input  logic              BREADY,
  input  logic [7:0]        ARADDR,
  input  logic              ARVALID,
  output logic              ARREADY,
  output logic [31:0]       RDATA,
  output logic [1:0]        RRESP,
  output logic              RVALID,
  input  logic              RREADY,
  input  logic              KEY_CONFIRM_PIN,
  input  logic              KEY_UP_PIN,
  input  logic              KEY_DOWN_PIN,
  input  logic              PORT0_LINK,
  input  logic              PORT1_LINK,
  input  logic [3:0]        SM_STATE,
  input  logic              SM_FAULT,
  input  logic [7:0]        OP_MODE,
  input  logic              DRIVE_ENABLED,
  output logic [6:0]        DIGIT1,
  output logic [6:0]        DIGIT2,
  output logic [6:0]        DIGIT3,
  output logic [6:0]        DIGIT4,
  output logic [6:0]        DIGIT5,
  output logic [26:0]       GEAR_NUMERATOR,
  output logic [26:0]       GEAR_DENOMINATOR,
  output logic              ENC_ABSOLUTE,
  output logic              ENC_MULTI_TURN,
  output logic              ENC_IGNORE_TURNS,
  output logic [4:0]        ENC_WORD_BITS,
  output spg_pkg::spg_word_t STATION_ALIAS
);
  import spg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  spg_word_t   p_q [0:6];
  spg_panel_e  pnl_q;
  spg_word_t   edit_val_q;
  spg_idx_t    edit_sel_q;
  logic        load_pend_q;
  logic        aw_ok_q;
  logic        w_ok_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        axi_wr;
  spg_idx_t    aw_idx;
  spg_idx_t    ar_idx;
  logic        wr_go;
  spg_idx_t    wr_idx;
  logic [31:0] wr_val;
  logic        wr_ok;
  logic        restore;
  logic [26:0] gear_num_c;
  logic [26:0] gear_den_c;
  logic        conf_hold;
  logic        up_press;
  logic        dn_press;

  function automatic spg_idx_t addr_idx(input logic [7:0] a);
    case (a)
      `SPG_OFS_NUM_HI:    addr_idx = `SPG_IDX_NUM_HI;
      `SPG_OFS_NUM_LO:    addr_idx = `SPG_IDX_NUM_LO;
      `SPG_OFS_DEN_HI:    addr_idx = `SPG_IDX_DEN_HI;
      `SPG_OFS_DEN_LO:    addr_idx = `SPG_IDX_DEN_LO;
      `SPG_OFS_ENC_KIND:  addr_idx = `SPG_IDX_ENC_KIND;
      `SPG_OFS_ABS_RES:   addr_idx = `SPG_IDX_ABS_RES;
      `SPG_OFS_ALIAS:     addr_idx = `SPG_IDX_ALIAS;
      `SPG_OFS_NUM:       addr_idx = `SPG_IDX_NUM;
      `SPG_OFS_DEN:       addr_idx = `SPG_IDX_DEN;
      `SPG_OFS_CTRL:      addr_idx = `SPG_IDX_CTRL;
      `SPG_OFS_EDIT_SEL:  addr_idx = `SPG_IDX_EDIT_SEL;
      `SPG_OFS_ALIAS_ACT: addr_idx = `SPG_IDX_ALIAS_ACT;
      `SPG_OFS_STATUS:    addr_idx = `SPG_IDX_STATUS;
      default:            addr_idx = `SPG_IDX_NONE;
    endcase
  endfunction

  // Out-of-range writes are refused whole; the stored word is kept.
  function automatic logic in_range(input spg_idx_t i, input logic [31:0] v);
    case (i)
      `SPG_IDX_NUM_HI, `SPG_IDX_DEN_HI: in_range = v <= `SPG_HI_MAX;
      `SPG_IDX_NUM_LO, `SPG_IDX_DEN_LO: in_range = v <= `SPG_LO_MAX;
      `SPG_IDX_ENC_KIND: in_range = v >= `SPG_ENC_MIN && v <= `SPG_ENC_MAX;
      `SPG_IDX_ABS_RES:  in_range = v <= `SPG_RES_MAX;
      `SPG_IDX_ALIAS:    in_range = v <= `SPG_ALIAS_MAX;
      `SPG_IDX_NUM, `SPG_IDX_DEN: in_range = v <= `SPG_COMPOSED_MAX;
      default:           in_range = 1'b0;
    endcase
  endfunction

  function automatic spg_word_t rst_val(input logic [2:0] i);
    case (i)
      3'h0:    rst_val = `SPG_NUM_HI_RST;
      3'h1:    rst_val = `SPG_NUM_LO_RST;
      3'h2:    rst_val = `SPG_DEN_HI_RST;
      3'h3:    rst_val = `SPG_DEN_LO_RST;
      3'h4:    rst_val = `SPG_ENC_KIND_RST;
      3'h5:    rst_val = `SPG_ABS_RES_RST;
      default: rst_val = `SPG_ALIAS_RST;
    endcase
  endfunction

  function automatic logic [6:0] seg7(input logic [3:0] v);
    case (v)
      4'h0:    seg7 = 7'h3f;
      4'h1:    seg7 = 7'h06;
      4'h2:    seg7 = 7'h5b;
      4'h3:    seg7 = 7'h4f;
      4'h4:    seg7 = 7'h66;
      4'h5:    seg7 = 7'h6d;
      4'h6:    seg7 = 7'h7d;
      4'h7:    seg7 = 7'h07;
      4'h8:    seg7 = 7'h7f;
      4'h9:    seg7 = 7'h6f;
      4'ha:    seg7 = 7'h77;
      default: seg7 = `SPG_SEG_DASH;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  spg_key #(.HOLD_CYCLES(HOLD_CYCLES)) u_key_confirm (
    .clk         (CLOCK),
    .rst         (RST),
    .key_pin     (KEY_CONFIRM_PIN),
    .press_pulse (),
    .hold_pulse  (conf_hold)
  );
  spg_key #(.HOLD_CYCLES(HOLD_CYCLES)) u_key_up (
    .clk         (CLOCK),
    .rst         (RST),
    .key_pin     (KEY_UP_PIN),
    .press_pulse (up_press),
    .hold_pulse  ()
  );
  spg_key #(.HOLD_CYCLES(HOLD_CYCLES)) u_key_down (
    .clk         (CLOCK),
    .rst         (RST),
    .key_pin     (KEY_DOWN_PIN),
    .press_pulse (dn_press),
    .hold_pulse  ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write side: address and data are taken in either order.
  assign AWREADY = !aw_ok_q && !BVALID;
  assign WREADY  = !w_ok_q && !BVALID;
  assign axi_wr  = aw_ok_q && w_ok_q && !BVALID;
  assign aw_idx  = addr_idx(awaddr_q);

  always_ff @(posedge CLOCK) begin
    if (RST || axi_wr) begin
      aw_ok_q <= 1'b0;
    end else if (AWVALID && AWREADY) begin
      aw_ok_q <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      awaddr_q <= 8'h00;
    end else if (AWVALID && AWREADY) begin
      awaddr_q <= AWADDR;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST || axi_wr) begin
      w_ok_q <= 1'b0;
    end else if (WVALID && WREADY) begin
      w_ok_q <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (WVALID && WREADY) begin
      wdata_q <= WDATA;
      wstrb_q <= WSTRB;
    end
  end

  // Partial-strobe writes are refused, as every field is taken whole.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      BVALID <= 1'b0;
      BRESP  <= `SPG_RESP_OKAY;
    end else if (axi_wr) begin
      BVALID <= 1'b1;
      if (wstrb_q == 4'hf && (in_range(aw_idx, wdata_q) ||
          aw_idx == `SPG_IDX_CTRL ||
          (aw_idx == `SPG_IDX_EDIT_SEL &&
           wdata_q <= {28'h0000000, `SPG_EDIT_SEL_MAX}))) begin
        BRESP <= `SPG_RESP_OKAY;
      end else begin
        BRESP <= `SPG_RESP_SLVERR;
      end
    end else if (BREADY) begin
      BVALID <= 1'b0;
    end
  end

  assign restore = axi_wr && wstrb_q == 4'hf && aw_idx == `SPG_IDX_CTRL &&
                   wdata_q[`SPG_CTRL_RESTORE];

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      edit_sel_q <= `SPG_EDIT_SEL_RST;
    end else if (axi_wr && wstrb_q == 4'hf && aw_idx == `SPG_IDX_EDIT_SEL &&
                 wdata_q <= {28'h0000000, `SPG_EDIT_SEL_MAX}) begin
      edit_sel_q <= wdata_q[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus writes win over a panel commit, which then waits one more cycle.
  always_comb begin
    if (axi_wr) begin
      wr_go  = wstrb_q == 4'hf;
      wr_idx = aw_idx;
      wr_val = wdata_q;
    end else begin
      wr_go  = pnl_q == PNL_COMMIT;
      wr_idx = edit_sel_q;
      wr_val = {16'h0000, edit_val_q};
    end
    wr_ok = wr_go && in_range(wr_idx, wr_val);
  end

  always_ff @(posedge CLOCK) begin
    if (RST || restore) begin
      for (int i = 0; i < 7; i++) begin
        p_q[i] <= rst_val(3'(i));
      end
    end else if (wr_ok) begin
      if (wr_idx == `SPG_IDX_NUM) begin
        p_q[0] <= 16'(wr_val[26:0] / `SPG_GEAR_SCALE);
        p_q[1] <= 16'(wr_val[26:0] % `SPG_GEAR_SCALE);
      end else if (wr_idx == `SPG_IDX_DEN) begin
        p_q[2] <= 16'(wr_val[26:0] / `SPG_GEAR_SCALE);
        p_q[3] <= 16'(wr_val[26:0] % `SPG_GEAR_SCALE);
      end else begin
        p_q[wr_idx[2:0]] <= wr_val[15:0];
      end
    end
  end

  assign gear_num_c = 27'(p_q[0]) * `SPG_GEAR_SCALE + 27'(p_q[1]);
  assign gear_den_c = 27'(p_q[2]) * `SPG_GEAR_SCALE + 27'(p_q[3]);

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      GEAR_NUMERATOR   <= 27'h0000000;
      GEAR_DENOMINATOR <= 27'h0000000;
    end else begin
      GEAR_NUMERATOR   <= gear_num_c;
      GEAR_DENOMINATOR <= gear_den_c;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ENC_ABSOLUTE     <= 1'b0;
      ENC_MULTI_TURN   <= 1'b0;
      ENC_IGNORE_TURNS <= 1'b0;
      ENC_WORD_BITS    <= `SPG_BITS_17;
    end else begin
      ENC_ABSOLUTE     <= p_q[4] == `SPG_ENC_MULTI_ABS ||
                          p_q[4] == `SPG_ENC_ABS_NOTURN;
      ENC_MULTI_TURN   <= p_q[4] != `SPG_ENC_SINGLE_INC;
      ENC_IGNORE_TURNS <= p_q[4] == `SPG_ENC_ABS_NOTURN;
      ENC_WORD_BITS    <= p_q[5] == `SPG_RES_17 ? `SPG_BITS_17 :
                          p_q[5] == `SPG_RES_20 ? `SPG_BITS_20 :
                          `SPG_BITS_23;
    end
  end

  // Alias edits never take effect: RST restores p_q[6] to its default before the one load.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      load_pend_q <= 1'b1;
    end else begin
      load_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      STATION_ALIAS <= `SPG_ALIAS_RST;
    end else if (load_pend_q) begin
      STATION_ALIAS <= p_q[6];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pnl_q <= PNL_BROWSE;
    end else begin
      unique case (pnl_q)
        PNL_BROWSE: if (conf_hold) pnl_q <= PNL_EDIT;
        PNL_EDIT:   if (conf_hold) pnl_q <= PNL_COMMIT;
        PNL_COMMIT: if (!axi_wr) pnl_q <= PNL_BROWSE;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      edit_val_q <= 16'h0000;
    end else if (pnl_q == PNL_BROWSE && conf_hold) begin
      edit_val_q <= p_q[edit_sel_q[2:0]];
    end else if (pnl_q == PNL_EDIT && up_press) begin
      edit_val_q <= edit_val_q + 16'h0001;
    end else if (pnl_q == PNL_EDIT && dn_press) begin
      edit_val_q <= edit_val_q - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Digits follow the live inputs every cycle, whatever page is edited.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      DIGIT1 <= 7'h00;
      DIGIT2 <= `SPG_SEG_DASH;
      DIGIT3 <= `SPG_SEG_DASH;
      DIGIT4 <= `SPG_SEG_DASH;
      DIGIT5 <= `SPG_SEG_DASH;
    end else begin
      DIGIT1 <= (PORT0_LINK ? `SPG_SEG_PORT0 : 7'h00) |
                (PORT1_LINK ? `SPG_SEG_PORT1 : 7'h00);
      DIGIT2 <= SM_FAULT ? `SPG_SEG_B : seg7(SM_STATE);
      DIGIT3 <= OP_MODE > `SPG_MODE_MAX ? `SPG_SEG_DASH :
                seg7(OP_MODE[3:0]);
      DIGIT4 <= DRIVE_ENABLED ? `SPG_SEG_O : `SPG_SEG_DASH;
      DIGIT5 <= DRIVE_ENABLED ? `SPG_SEG_N : `SPG_SEG_DASH;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign ARREADY = !RVALID;
  assign ar_idx  = addr_idx(ARADDR);

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      RVALID <= 1'b0;
      RDATA  <= 32'h0000_0000;
      RRESP  <= `SPG_RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      RRESP  <= `SPG_RESP_OKAY;
      RDATA  <= 32'h0000_0000;
      if (ar_idx <= `SPG_IDX_ALIAS) begin
        RDATA <= {16'h0000, p_q[ar_idx[2:0]]};
      end else if (ar_idx == `SPG_IDX_NUM) begin
        RDATA <= {5'h00, GEAR_NUMERATOR};
      end else if (ar_idx == `SPG_IDX_DEN) begin
        RDATA <= {5'h00, GEAR_DENOMINATOR};
      end else if (ar_idx == `SPG_IDX_EDIT_SEL) begin
        RDATA <= {28'h0000000, edit_sel_q};
      end else if (ar_idx == `SPG_IDX_ALIAS_ACT) begin
        RDATA <= {16'h0000, STATION_ALIAS};
      end else if (ar_idx == `SPG_IDX_STATUS) begin
        RDATA <= {edit_val_q, 6'h00, pnl_q, DRIVE_ENABLED, SM_FAULT,
                  SM_STATE, PORT1_LINK, PORT0_LINK};
      end else if (ar_idx == `SPG_IDX_NONE) begin
        RRESP <= `SPG_RESP_SLVERR;
      end
    end else if (RREADY) begin
      RVALID <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_num_write;
    axi_wr && wr_ok && wr_idx == `SPG_IDX_NUM;
  endsequence
  sequence s_open;
    pnl_q == PNL_BROWSE && conf_hold;
  endsequence
  sequence s_commit;
    pnl_q == PNL_COMMIT && !axi_wr && wr_ok;
  endsequence

  AST_NUM_DEFAULT: assert property (
    (p_q[0] == 16'h000d && p_q[1] == 16'h0430)[*2] |->
      GEAR_NUMERATOR == 27'h0020000)
    else $error("numerator not composed from its words");
  AST_DEN_DEFAULT: assert property (
    (p_q[2] == 16'h0001 && p_q[3] == 16'h0000)[*2] |->
      GEAR_DENOMINATOR == 27'h0002710)
    else $error("denominator not composed from its words");
  AST_NUM_SPLIT: assert property (
    s_num_write |-> ##2 GEAR_NUMERATOR == $past(wdata_q[26:0], 2))
    else $error("numerator object write not reflected");
  AST_DEN_SPLIT: assert property (
    (axi_wr && wr_ok && wr_idx == `SPG_IDX_DEN) |->
      ##2 GEAR_DENOMINATOR == $past(wdata_q[26:0], 2))
    else $error("denominator object write not reflected");
  AST_ENC_REJECT: assert property (
    (axi_wr && aw_idx == `SPG_IDX_ENC_KIND && !restore &&
     (wdata_q == 32'h0 || wdata_q > 32'h4)) |=>
      $stable(p_q[4]) && BVALID && BRESP == `SPG_RESP_SLVERR)
    else $error("bad encoder kind accepted");
  AST_IGNORE_TURNS: assert property (
    p_q[4] == 16'h0004 |=> ENC_IGNORE_TURNS && ENC_ABSOLUTE)
    else $error("kind four must ignore turns");
  AST_RES_BITS: assert property (
    p_q[5] == 16'h0001 |=> ENC_WORD_BITS == 5'h14)
    else $error("resolution one must give 20 bits");
  AST_STATE_CODE: assert property (
    (!SM_FAULT && SM_STATE == 4'h8) |=> DIGIT2 == 7'h7f)
    else $error("operational state code not shown");
  AST_FAULT_B: assert property (
    SM_FAULT |=> DIGIT2 == 7'h7c)
    else $error("fault not shown as B");
  AST_MODE_TEN: assert property (
    OP_MODE == 8'h0a |=> DIGIT3 == 7'h77)
    else $error("mode ten not shown");
  AST_MODE_CSP: assert property (
    OP_MODE == 8'h08 |=> DIGIT3 == 7'h7f)
    else $error("mode eight not shown");
  AST_LINK: assert property (
    1'b1 |=> DIGIT1[5] == $past(PORT0_LINK) && DIGIT1[1] == $past(PORT1_LINK))
    else $error("link segment wrong");
  AST_RUN: assert property (
    DRIVE_ENABLED |=> DIGIT4 == 7'h3f && DIGIT5 == 7'h54)
    else $error("enabled drive not shown as On");
  AST_OPEN: assert property (
    s_open |=> pnl_q == PNL_EDIT ##0 edit_val_q == $past(p_q[edit_sel_q[2:0]]))
    else $error("long hold did not open the editor");
  AST_NO_OPEN: assert property (
    (pnl_q == PNL_BROWSE && !conf_hold) |=> pnl_q == PNL_BROWSE)
    else $error("editor opened without long hold");
  AST_COMMIT: assert property (
    s_commit |=> pnl_q == PNL_BROWSE &&
      p_q[$past(edit_sel_q[2:0])] == $past(edit_val_q))
    else $error("edited value not committed");
  AST_RESTORE: assert property (
    restore |=> p_q[0] == 16'h000d && p_q[4] == 16'h0002 && p_q[6] == 16'h0)
    else $error("factory restore incomplete");
  AST_ALIAS: assert property (
    !load_pend_q |=> $stable(STATION_ALIAS))
    else $error("alias changed after power-on");
endmodule

// [spg_opr.sv]
`timescale 1ns/1ps
module spg_opr (
  input  wire logic clk,
  output logic      key_confirm,
  output logic      key_up,
  output logic      key_down
);
  initial begin
    key_confirm = 1'h0;
    key_up      = 1'h0;
    key_down    = 1'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // A press is held whole cycles; the rest lets the synchroniser drain.
  task automatic press(input int k, input int n);
    @(posedge clk);
    key_confirm <= (k == 0);
    key_up      <= (k == 1);
    key_down    <= (k == 2);
    repeat (n) @(posedge clk);
    {key_confirm, key_up, key_down} <= 3'h0;
    repeat (6) @(posedge clk);
  endtask
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import spg_pkg::*;
  logic clk = 1'h0, rst = 1'h1, p0 = 1'h0, p1 = 1'h0, flt = 1'h0, en = 1'h0;
  logic aw_v = 1'h0, w_v = 1'h0, b_r = 1'h0, ar_v = 1'h0, r_r = 1'h0;
  logic [7:0] aw_a = 8'h00, ar_a = 8'h00, mode = 8'h00;
  logic [31:0] w_d = 32'h0, r_d, d;
  logic aw_r, w_r, b_v, ar_r, r_v, kc, ku, kd, eabs, emul, eign;
  logic [1:0] b_s, r_s;
  logic [3:0] sm = 4'h1, ws = 4'hf;
  logic [6:0] d1, d2, d3, d4, d5;
  logic [26:0] gnum, gden;
  logic [4:0] ebits;
  spg_word_t act_alias;
  int miscompares = 0, total_checks = 0, cyc = 0;
  // Row packing: {port0, port1, state, fault, enable, mode}.
  logic [15:0] rin [5] = '{16'h8400, 16'h4908, 16'hd00a, 16'h230b, 16'h2000};
  logic [4:0][6:0] rout [5] = '{'{7'h20, 7'h06, 7'h3f, 7'h40, 7'h40},
    '{7'h02, 7'h5b, 7'h7f, 7'h3f, 7'h54}, '{7'h22, 7'h66, 7'h77, 7'h40, 7'h40},
    '{7'h00, 7'h7c, 7'h40, 7'h3f, 7'h54},
    '{7'h00, 7'h7f, 7'h3f, 7'h40, 7'h40}};
  logic [2:0] ek [4] = '{3'h0, 3'h6, 3'h2, 3'h7};
  spg_panel_cfg #(.HOLD_CYCLES(8)) spg_panel_cfg_inst (
    .CLOCK(clk), .RST(rst), .AWADDR(aw_a), .AWVALID(aw_v), .AWREADY(aw_r),
    .WDATA(w_d), .WSTRB(ws), .WVALID(w_v), .WREADY(w_r), .BRESP(b_s),
    .BVALID(b_v), .BREADY(b_r), .ARADDR(ar_a), .ARVALID(ar_v),
    .ARREADY(ar_r), .RDATA(r_d), .RRESP(r_s), .RVALID(r_v), .RREADY(r_r),
    .KEY_CONFIRM_PIN(kc), .KEY_UP_PIN(ku), .KEY_DOWN_PIN(kd),
    .PORT0_LINK(p0), .PORT1_LINK(p1), .SM_STATE(sm), .SM_FAULT(flt),
    .OP_MODE(mode), .DRIVE_ENABLED(en), .DIGIT1(d1), .DIGIT2(d2),
    .DIGIT3(d3), .DIGIT4(d4), .DIGIT5(d5), .GEAR_NUMERATOR(gnum),
    .GEAR_DENOMINATOR(gden), .ENC_ABSOLUTE(eabs), .ENC_MULTI_TURN(emul),
    .ENC_IGNORE_TURNS(eign), .ENC_WORD_BITS(ebits), .STATION_ALIAS(act_alias));
  spg_opr spg_opr_inst (.clk(clk), .key_confirm(kc), .key_up(ku),
    .key_down(kd));
  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(string n, logic [34:0] e, logic [34:0] g);
    total_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask
  // Handshakes are sampled right after the edge, before the slave updates.
  task automatic wr(logic [7:0] a, logic [31:0] v, logic [1:0] er);
    {aw_a, w_d, aw_v, w_v, b_r} <= {a, v, 3'h7};
    do begin
      @(posedge clk);
      if (aw_r) aw_v <= 1'h0;
      if (w_r) w_v <= 1'h0;
    end while (!b_v);
    b_r <= 1'h0;
    chk("bresp", 35'(er), 35'(b_s));
    @(posedge clk);
  endtask
  task automatic rd(logic [7:0] a, logic [1:0] er);
    {ar_a, ar_v, r_r} <= {a, 2'h3};
    do begin
      @(posedge clk);
      if (ar_r) ar_v <= 1'h0;
    end while (!r_v);
    {d, r_r} <= {r_d, 1'h0};
    chk("rresp", 35'(er), 35'(r_s));
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    chk("gnum", 35'h20000, 35'(gnum));
    chk("gden", 35'h2710, 35'(gden));
    chk("ebits", 35'h11, 35'(ebits));
    for (int i = 0; i < 5; i++) begin
      {p0, p1, sm, flt, en, mode} <= rin[i];
      repeat (3) @(posedge clk);
      chk("digits", 35'(rout[i]), {d1, d2, d3, d4, d5});
    end
    wr(8'h00, 32'h2710, 2'h0);
    wr(8'h04, 32'h270f, 2'h0);
    rd(8'h1c, 2'h0);
    chk("gnum", 35'h5f6080f, 35'(gnum));
    chk("num", 35'h5f6080f, 35'(d));
    wr(8'h20, 32'hc350, 2'h0);
    rd(8'h08, 2'h0);
    chk("den_hi", 35'h5, 35'(d));
    chk("gden", 35'hc350, 35'(gden));
    wr(8'h1c, 32'h20000, 2'h0);
    rd(8'h04, 2'h0);
    chk("num_lo", 35'h430, 35'(d));
    for (int k = 1; k < 5; k++) begin
      wr(8'h10, 32'(k), 2'h0);
      repeat (2) @(posedge clk);
      chk("enc", 35'(ek[k-1]), 35'({eabs, emul, eign}));
      wr(8'h14, 32'(k - 1), (k == 4) ? 2'h2 : 2'h0);
      repeat (2) @(posedge clk);
      if (k < 4) chk("ebits", 35'(17 + 3 * (k - 1)), 35'(ebits));
    end
    wr(8'h10, 32'h0, 2'h2);
    wr(8'h10, 32'h5, 2'h2);
    rd(8'h3c, 2'h2);
    ws <= 4'h3;
    wr(8'h10, 32'h1, 2'h2);
    ws <= 4'hf;
    chk("enc", 35'h7, 35'({eabs, emul, eign}));
    wr(8'h18, 32'h1234, 2'h0);
    wr(8'h24, 32'h1, 2'h0);
    chk("alias", 35'h0, 35'(act_alias));
    rd(8'h00, 2'h0);
    chk("num_hi", 35'hd, 35'(d));
    wr(8'h28, 32'h6, 2'h0);
    spg_opr_inst.press(0, 4);
    rd(8'h30, 2'h0);
    chk("panel", 35'h0, 35'(d[9:8]));
    spg_opr_inst.press(0, 14);
    rd(8'h30, 2'h0);
    chk("panel", 35'h1, 35'(d[9:8]));
    spg_opr_inst.press(1, 2);
    spg_opr_inst.press(2, 2);
    spg_opr_inst.press(1, 2);
    spg_opr_inst.press(0, 14);
    rd(8'h18, 2'h0);
    chk("alias_par", 35'h1, 35'(d));
    chk("alias", 35'h0, 35'(act_alias));
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    chk("alias", 35'h0, 35'(act_alias));
    chk("gnum", 35'h20000, 35'(gnum));
    chk("enc", 35'h6, 35'({eabs, emul, eign}));
    stop_test();
  end
endmodule
